// >>> sabc_top.sv
// Track, burst and SAR sequencing control for a 10-bit converter, with its register file.
// Assumes an analog core that follows track_out/dac_code_out and returns a comparator level.
// Operation
// - Burst off, delayed track off: input tracks always except during conversion.
// - Delayed track: each conversion preceded by 3 SAR clocks of tracking.
// - External start in delayed track: track while pin low, convert on rise.
// - Burst: wake, run and accumulate 1..64 conversions, then low power.
// - Burst bit set enables burst; cleared, SAR clock comes from system clock.
// - In burst, enable bit picks idle state: 0 powered down, 1 enabled.
// - Burst start: powered-down converter waits power-up time; enabled starts at once.
// - Burst: one start runs repeat-count conversions; otherwise one start per conversion.
// - Done flag set only after repeat-count conversions accumulated.
// - Window compare happens only after repeat-count conversions accumulated.
// - Burst tracking from power-up and track-time; delayed track adds 3 clocks. Track is held low during power-up here.
// - Gain bit selects 1x or 0.5x input gain.
// - 8-bit mode resolves only 8 MSBs, two SAR clocks shorter.
// - 8-bit mode: two LSBs are 00; with repeat 1, low result byte reads 0x00.
// - Burst off: enable 0 is shutdown, 1 is active and ready.
// - Done flag set at end of conversion series or burst; software clears it.
// - Writing 1 to busy starts a conversion only with source 000.
// - Window flag set when result inside window; software clears it.
// - Source select: busy write, timer 0, timer 2, timer 3, external pin.
// - Tracking shut down in standby or sleep.
// - Busy reads 1 during conversion; its fall after the final conversion sets the done flag.
// - Repeat above 1: result holds the sum, updated after final conversion.
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none

module sabc_top
  import sabc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [11:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic timer0_ovf_in,
  input wire logic timer2_ovf_in,
  input wire logic timer3_ovf_in,
  input wire logic external_convert_start_in,
  input wire logic comparator_in,
  input wire logic standby_in,
  output logic adc_power_out,
  output logic track_out,
  output logic [9:0] dac_code_out,
  output logic input_gain_select_out
);

  // Register state
  logic en_q, burst_q, done_q, win_q;
  logic [2:0] src_q;
  logic [4:0] sc_q;
  logic eight_q, dtrack_q;
  logic [2:0] rpt_q;
  logic [3:0] pwr_q;
  logic [5:0] tk_q;
  logic [15:0] upper_q, lower_q, result_q;
  logic waitreq_q;
  logic [31:0] rdata_q;

  // Sequencer state
  sabc_state_t st_q;
  logic [6:0] cnt_q, nconv_q;
  logic [3:0] bit_q;
  logic [9:0] code_q;
  logic [15:0] acc_q;
  logic [4:0] tdiv_q;
  logic track_q, power_q;

  // Synchronisers: t0, t2, t3, pin, comparator, standby
  logic [5:0] s1_q, s2_q;
  logic [3:0] prev_q;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
      prev_q <= 4'h0;
    end else begin
      s1_q <= {standby_in, comparator_in, external_convert_start_in, timer3_ovf_in, timer2_ovf_in, timer0_ovf_in};
      s2_q <= s1_q;
      prev_q <= s2_q[3:0];
    end
  end

  logic [3:0] rise;
  logic cnv_s, comp_s, standby_s;
  assign rise = s2_q[3:0] & ~prev_q;
  assign cnv_s = s2_q[3];
  assign comp_s = s2_q[4];
  assign standby_s = s2_q[5];

  // Avalon-MM slave: one wait cycle, write and read data at the edge waitrequest is low
  logic req, acc_w, wr_lo, wr_hi;
  assign req = avs_read_in | avs_write_in;
  assign acc_w = avs_write_in & ~waitreq_q;
  assign wr_lo = acc_w & avs_byteenable_in[0];
  assign wr_hi = acc_w & avs_byteenable_in[1];

  logic wr_ctrl;
  assign wr_ctrl = wr_lo && (avs_address_in == OFS_CTRL);

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      waitreq_q <= 1'b1;
    end else begin
      waitreq_q <= ~(req & waitreq_q);
    end
  end

  logic busy;
  assign busy = (st_q != ST_IDLE);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address_in)
      OFS_CTRL: rd_mux[7:0] = {en_q, burst_q, done_q, busy, win_q, src_q};
      OFS_CFG: rd_mux[7:0] = {sc_q, eight_q, dtrack_q, input_gain_select_out};
      OFS_ACC: rd_mux[2:0] = rpt_q;
      OFS_BTIME: rd_mux[9:0] = {tk_q, pwr_q};
      OFS_RESULT: rd_mux[15:0] = result_q;
      OFS_UPPER: rd_mux[15:0] = upper_q;
      OFS_LOWER: rd_mux[15:0] = lower_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_in && waitreq_q) begin
      rdata_q <= rd_mux;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_q <= 1'b0;
      burst_q <= 1'b0;
      src_q <= SRC_RST;
      sc_q <= SC_RST;
      eight_q <= 1'b0;
      dtrack_q <= 1'b0;
      input_gain_select_out <= 1'b0;
      rpt_q <= RPT_RST;
      pwr_q <= PWR_RST;
      tk_q <= TK_RST;
      upper_q <= UPPER_RST;
      lower_q <= LOWER_RST;
    end else begin
      if (wr_ctrl) begin
        en_q <= avs_writedata_in[CTRL_EN_BIT];
        burst_q <= avs_writedata_in[CTRL_BURST_BIT];
        src_q <= avs_writedata_in[2:0];
      end
      if (wr_lo && avs_address_in == OFS_CFG) begin
        sc_q <= avs_writedata_in[CFG_SC_LSB +: 5];
        eight_q <= avs_writedata_in[CFG_EIGHT_BIT];
        dtrack_q <= avs_writedata_in[CFG_DTRACK_BIT];
        input_gain_select_out <= avs_writedata_in[CFG_GAIN_BIT];
      end
      if (wr_lo && avs_address_in == OFS_ACC) begin
        rpt_q <= avs_writedata_in[2:0];
      end
      if (avs_address_in == OFS_BTIME) begin
        if (wr_lo) begin
          pwr_q <= avs_writedata_in[3:0];
          tk_q[3:0] <= avs_writedata_in[7:4];
        end
        if (wr_hi) begin
          tk_q[5:4] <= avs_writedata_in[9:8];
        end
      end
      if (avs_address_in == OFS_UPPER) begin
        if (wr_lo) upper_q[7:0] <= avs_writedata_in[7:0];
        if (wr_hi) upper_q[15:8] <= avs_writedata_in[15:8];
      end
      if (avs_address_in == OFS_LOWER) begin
        if (wr_lo) lower_q[7:0] <= avs_writedata_in[7:0];
        if (wr_hi) lower_q[15:8] <= avs_writedata_in[15:8];
      end
    end
  end

  // Start selection; field value after the same write counts for a busy write
  logic sw_go, hw_go, start_go;
  assign sw_go = wr_ctrl && avs_writedata_in[CTRL_BUSY_BIT] && (avs_writedata_in[2:0] == SRC_SW);
  always_comb begin
    hw_go = 1'b0;
    unique case (src_q)
      SRC_SW: hw_go = 1'b0;
      SRC_T0: hw_go = rise[0];
      SRC_T2: hw_go = rise[1];
      SRC_T3: hw_go = rise[2];
      default: hw_go = rise[3];
    endcase
  end
  // Starts during a burst are dropped, so sources must keep their spacing
  assign start_go = (sw_go | hw_go) && (burst_q || en_q) && (st_q == ST_IDLE);

  // SAR clock tick; divider floor leaves room for the comparator synchroniser
  logic [4:0] eff_div;
  logic tick;
  assign eff_div = (sc_q < MIN_SAR_DIV) ? MIN_SAR_DIV : sc_q;
  assign tick = (tdiv_q == 5'h00);

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tdiv_q <= 5'h00;
    end else if (st_q == ST_IDLE || tick) begin
      tdiv_q <= eff_div;
    end else begin
      tdiv_q <= tdiv_q - 5'h01;
    end
  end

  // Conversion arithmetic
  logic [3:0] last_bit;
  logic [9:0] code_now;
  logic [15:0] sum_d, final_val;
  logic [6:0] rpt_n, trk_load;
  logic conv_end, series_end, in_win;

  assign last_bit = eight_q ? LAST_BIT_8 : LAST_BIT_10;
  assign rpt_n = sabc_rpt_count(rpt_q);
  assign trk_load = {1'b0, tk_q} + (dtrack_q ? DLY_TRACK_TICKS : 7'h00);
  assign conv_end = (st_q == ST_CONV) && tick && (bit_q == last_bit);
  assign series_end = ((nconv_q + 7'h01) == rpt_n);
  assign sum_d = acc_q + {6'h00, code_now};
  assign final_val = (eight_q && rpt_q == 3'h0) ? {code_now[9:2], 8'h00} : sum_d;
  assign in_win = (final_val > upper_q) && (final_val < lower_q);

  always_comb begin
    code_now = code_q;
    code_now[bit_q] = comp_s;
  end

  // Sequencer
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= ST_IDLE;
      cnt_q <= 7'h00;
      bit_q <= MSB_INDEX;
      code_q <= 10'h000;
      nconv_q <= 7'h00;
      acc_q <= 16'h0000;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (start_go) begin
            if (nconv_q == 7'h00) acc_q <= 16'h0000;
            if (burst_q && !en_q) begin
              st_q <= ST_PWRUP;
              cnt_q <= {3'h0, pwr_q};
            end else if (burst_q) begin
              st_q <= ST_TRACK;
              cnt_q <= trk_load;
            end else if (dtrack_q && !src_q[2]) begin
              st_q <= ST_TRACK;
              cnt_q <= DLY_TRACK_TICKS - 7'h01;
            end else begin
              st_q <= ST_CONV;
              bit_q <= MSB_INDEX;
              code_q <= 10'h200;
            end
          end
        end
        ST_PWRUP: begin
          if (tick) begin
            if (cnt_q == 7'h00) begin
              st_q <= ST_TRACK;
              cnt_q <= trk_load;
            end else begin
              cnt_q <= cnt_q - 7'h01;
            end
          end
        end
        ST_TRACK: begin
          if (tick) begin
            if (cnt_q == 7'h00) begin
              st_q <= ST_CONV;
              bit_q <= MSB_INDEX;
              code_q <= 10'h200;
            end else begin
              cnt_q <= cnt_q - 7'h01;
            end
          end
        end
        ST_CONV: begin
          if (tick) begin
            if (bit_q == last_bit) begin
              code_q <= code_now;
              acc_q <= sum_d;
              if (series_end) begin
                nconv_q <= 7'h00;
                st_q <= ST_IDLE;
              end else begin
                nconv_q <= nconv_q + 7'h01;
                if (burst_q) begin
                  st_q <= ST_TRACK;
                  cnt_q <= trk_load;
                end else begin
                  st_q <= ST_IDLE;
                end
              end
            end else begin
              code_q <= code_now;
              code_q[bit_q - 4'h1] <= 1'b1;
              bit_q <= bit_q - 4'h1;
            end
          end
        end
      endcase
    end
  end

  // Result and flags; a hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_q <= 16'h0000;
      done_q <= 1'b0;
      win_q <= 1'b0;
    end else begin
      if (conv_end && series_end) result_q <= final_val;
      if (conv_end && series_end) begin
        done_q <= 1'b1;
      end else if (wr_ctrl) begin
        done_q <= avs_writedata_in[CTRL_DONE_BIT];
      end
      if (conv_end && series_end && in_win) begin
        win_q <= 1'b1;
      end else if (wr_ctrl) begin
        win_q <= avs_writedata_in[CTRL_WIN_BIT];
      end
    end
  end

  // Track and power controls to the analog core
  logic track_d, power_d;
  always_comb begin
    track_d = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        if (!burst_q && en_q) begin
          if (!dtrack_q) track_d = 1'b1;
          else if (src_q[2]) track_d = ~cnv_s;
        end
      end
      ST_PWRUP: track_d = 1'b0;
      ST_TRACK: track_d = 1'b1;
      ST_CONV: track_d = 1'b0;
    endcase
    track_d = track_d & ~standby_s;
    power_d = burst_q ? (en_q || st_q != ST_IDLE) : en_q;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      track_q <= 1'b0;
      power_q <= 1'b0;
    end else begin
      track_q <= track_d;
      power_q <= power_d;
    end
  end

  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = waitreq_q;
  assign track_out = track_q;
  assign adc_power_out = power_q;
  assign dac_code_out = code_q;

  // Checks
  property p_cont_track;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (st_q == ST_IDLE && !burst_q && en_q && !dtrack_q && !standby_s) |=> track_q;
  endproperty
  a_cont_track: assert property (p_cont_track) else $error("continuous tracking lost");

  property p_delay_track;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ($rose(st_q == ST_CONV) && !burst_q && dtrack_q && !src_q[2]) |-> ($past(st_q) == ST_TRACK);
  endproperty
  a_delay_track: assert property (p_delay_track) else $error("conversion without delayed tracking");

  property p_pin_track;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (st_q == ST_IDLE && !burst_q && en_q && dtrack_q && src_q[2] && !standby_s) |=> (track_q == !$past(cnv_s));
  endproperty
  a_pin_track: assert property (p_pin_track) else $error("tracking does not follow start pin");

  property p_burst_idle_power;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (st_q == ST_IDLE && burst_q && !en_q) [*2] |-> !power_q;
  endproperty
  a_burst_idle_power: assert property (p_burst_idle_power) else $error("powered between bursts");

  property p_burst_wake;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (start_go && burst_q) |=> (st_q == ($past(en_q) ? ST_TRACK : ST_PWRUP));
  endproperty
  a_burst_wake: assert property (p_burst_wake) else $error("wrong wake path in burst");

  property p_single_start;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (conv_end && !burst_q && !series_end && !wr_ctrl) |=> (st_q == ST_IDLE && done_q == $past(done_q))
      ##1 (st_q == ST_IDLE || $past(start_go));
  endproperty
  a_single_start: assert property (p_single_start) else $error("conversion ran without a start");

  property p_done_set;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (conv_end && series_end) |=> (done_q && !busy && result_q == $past(final_val));
  endproperty
  a_done_set: assert property (p_done_set) else $error("series end did not set done");

  property p_shutdown;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (!burst_q && !en_q && st_q == ST_IDLE) |=> (st_q == ST_IDLE && !power_q);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("disabled converter left shutdown");

  property p_eight_lsb;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (conv_end && eight_q) |-> (code_now[1:0] == 2'b00 && $past(st_q, 2) == ST_CONV);
  endproperty
  a_eight_lsb: assert property (p_eight_lsb) else $error("8-bit conversion resolved low bits");

  property p_window;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (conv_end && series_end && in_win) |=> win_q ##1 (win_q || $past(wr_ctrl));
  endproperty
  a_window: assert property (p_window) else $error("window hit not flagged");

endmodule : sabc_top

`default_nettype wire

// >>> sabc_pkg.sv
// Constants, register map and types for the SAR converter track/burst controller.
// Assumes a 25 MHz system clock and a 32-bit Avalon-MM register bus.
package sabc_pkg;

  localparam int CLK_HZ = 25_000_000;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h0e8;
  localparam logic [11:0] OFS_CFG = 12'h0f0;
  localparam logic [11:0] OFS_ACC = 12'h0f4;
  localparam logic [11:0] OFS_BTIME = 12'h0f8;
  localparam logic [11:0] OFS_RESULT = 12'h0fc;
  localparam logic [11:0] OFS_UPPER = 12'h100;
  localparam logic [11:0] OFS_LOWER = 12'h104;

  // Control register field positions
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_BURST_BIT = 6;
  localparam int CTRL_DONE_BIT = 5;
  localparam int CTRL_BUSY_BIT = 4;
  localparam int CTRL_WIN_BIT = 3;

  // Configuration register field positions
  localparam int CFG_SC_LSB = 3;
  localparam int CFG_EIGHT_BIT = 2;
  localparam int CFG_DTRACK_BIT = 1;
  localparam int CFG_GAIN_BIT = 0;

  // Burst timing register field positions
  localparam int BT_TK_LSB = 4;

  // Values after reset
  localparam logic [2:0] SRC_RST = 3'h0;
  localparam logic [4:0] SC_RST = 5'h1f;
  localparam logic [2:0] RPT_RST = 3'h0;
  localparam logic [3:0] PWR_RST = 4'h4;
  localparam logic [5:0] TK_RST = 6'h07;
  localparam logic [15:0] UPPER_RST = 16'hffff;
  localparam logic [15:0] LOWER_RST = 16'h0000;

  // Start-of-conversion sources; 1xx is the external pin
  localparam logic [2:0] SRC_SW = 3'h0;
  localparam logic [2:0] SRC_T0 = 3'h1;
  localparam logic [2:0] SRC_T2 = 3'h2;
  localparam logic [2:0] SRC_T3 = 3'h3;

  // Track count in SAR clock ticks, SAR divider floor and bit indices
  localparam logic [6:0] DLY_TRACK_TICKS = 7'h03;
  localparam logic [4:0] MIN_SAR_DIV = 5'h02;
  localparam logic [3:0] MSB_INDEX = 4'h9;
  localparam logic [3:0] LAST_BIT_10 = 4'h0;
  localparam logic [3:0] LAST_BIT_8 = 4'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_PWRUP, ST_TRACK, ST_CONV} sabc_state_t;

  function automatic logic [6:0] sabc_rpt_count(input logic [2:0] code);
    logic [6:0] n;
    n = 7'h40;
    unique case (code)
      3'h0: n = 7'h01;
      3'h1: n = 7'h04;
      3'h2: n = 7'h08;
      3'h3: n = 7'h10;
      3'h4: n = 7'h20;
      default: n = 7'h40;
    endcase
    return n;
  endfunction : sabc_rpt_count

endpackage : sabc_pkg

// >>> sabc_core_model.sv
// Behavioural model of the analog SAR core behind the controller.
// Assumes the controller drives power, track and trial code, and syncs the comparator itself.
`timescale 1ns/10ps
`default_nettype none

module sabc_core_model (
  input wire logic clk_sys_in,
  input wire logic adc_power_in,
  input wire logic track_in,
  input wire logic [9:0] dac_code_in,
  input wire logic gain_in,
  input wire logic [9:0] level_in,
  output logic comparator_out
);
  logic [9:0] held_q = 10'h000;
  logic junk_q = 1'b0;
  logic [9:0] eff;

  // Half gain halves the input seen by the converter
  assign eff = gain_in ? level_in : {1'b0, level_in[9:1]};

  always @(posedge clk_sys_in) begin
    junk_q <= ~junk_q;
    if (adc_power_in && track_in) begin
      held_q <= eff;
    end
  end

  // Unpowered core gives no valid decision, so it toggles
  assign comparator_out = adc_power_in ? (held_q >= dac_code_in) : junk_q;
endmodule : sabc_core_model

`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the SAR track/burst controller.
// Assumes the core model file is compiled first; drives Avalon-MM, timers, pin and standby.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import sabc_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [11:0] avs_address_in = 12'h000;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'h3;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [3:0] trig = 4'h0;
  logic comparator_in;
  logic standby_in = 1'b0;
  logic adc_power_out, track_out, input_gain_select_out;
  logic [9:0] dac_code_out;
  logic [9:0] level = 10'h000;
  logic [31:0] rd;
  int n_errors = 0;
  int check_count = 0;
  int seed = 32'h96af8aba;
  int cyc = 0;
  int run_n, phase, run_t[4];
  logic meas = 1'b0;
  logic run_lvl = 1'b0;

  always #20 clk_sys_in = ~clk_sys_in;

  sabc_top i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .timer0_ovf_in(trig[1]), .timer2_ovf_in(trig[2]),
    .timer3_ovf_in(trig[3]), .external_convert_start_in(trig[0]), .comparator_in(comparator_in),
    .standby_in(standby_in), .adc_power_out(adc_power_out), .track_out(track_out),
    .dac_code_out(dac_code_out), .input_gain_select_out(input_gain_select_out));

  sabc_core_model i_core (.clk_sys_in(clk_sys_in), .adc_power_in(adc_power_out), .track_in(track_out),
    .dac_code_in(dac_code_out), .gain_in(input_gain_select_out), .level_in(level),
    .comparator_out(comparator_in));

  task test_done;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // Timeout; probe times the run of track_out that follows its first change once armed
  always @(posedge clk_sys_in) begin
    cyc++;
    if (meas) begin
      if (track_out !== run_lvl) begin
        run_lvl = track_out;
        phase++;
      end
      if (phase == 1) begin
        run_n++;
      end
    end
    if (cyc >= 60000) begin
      n_errors++;
      test_done();
    end
  end

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    avs_address_in <= a;
    avs_writedata_in <= d;
    @(posedge clk_sys_in);
    while (avs_waitrequest_out !== 1'b0) begin
      @(posedge clk_sys_in);
    end
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : bus

  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task poll(input int b, input logic v);
    int k;
    k = 0;
    do begin
      bus(1'b0, OFS_CTRL, 32'h0);
      k++;
    end while (rd[b] !== v && k < 400);
  endtask : poll

  // Pulse width and spacing well above four clocks
  task fire(input logic [2:0] s);
    int i;
    i = s[2] ? 0 : int'(s[1:0]);
    trig[i] <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    trig[i] <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
  endtask : fire

  function automatic logic [31:0] expect_res(input logic [9:0] v, input logic g, input logic e, input int n);
    logic [9:0] eff;
    eff = g ? v : {1'b0, v[9:1]};
    return e ? {16'h0, eff[9:2], 8'h00} : 32'(eff) * n;
  endfunction : expect_res

  logic [7:0] cfg;
  logic [2:0] s;
  initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    bus(1'b0, OFS_CTRL, 32'h0);
    check("ctrl reset", 32'h0, rd);
    bus(1'b0, OFS_CFG, 32'h0);
    check("cfg reset", 32'hf8, rd);
    bus(1'b0, 12'h200, 32'h0);
    check("unmapped", 32'h0, rd);
    wr(OFS_CTRL, 32'h10);
    repeat (100) @(posedge clk_sys_in);
    check("power while disabled", 1'b0, adc_power_out);
    poll(CTRL_DONE_BIT, 1'b1);
    check("start while disabled", 1'b0, rd[CTRL_DONE_BIT]);
    // 0: normal 10-bit, 1: 8-bit, 2: delayed track, 3: half gain
    for (int t = 0; t < 4; t++) begin
      cfg = {5'h02, t == 1, t == 2, t != 3};
      level = 10'($random(seed));
      wr(OFS_CFG, {24'h0, cfg});
      wr(OFS_CTRL, 32'h80);
      repeat (20) @(posedge clk_sys_in);
      if (t != 2) check("idle tracking", 1'b1, track_out);
      run_n = 0;
      phase = 0;
      run_lvl = track_out;
      meas = 1'b1;
      wr(OFS_CTRL, 32'h90);
      poll(CTRL_DONE_BIT, 1'b1);
      meas = 1'b0;
      check("busy after done", 1'b0, rd[CTRL_BUSY_BIT]);
      run_t[t] = run_n;
      bus(1'b0, OFS_RESULT, 32'h0);
      check("result", expect_res(level, cfg[0], cfg[2], 1), rd);
      wr(OFS_CTRL, 32'h80);
      bus(1'b0, OFS_CTRL, 32'h0);
      check("done cleared", 1'b0, rd[CTRL_DONE_BIT]);
    end
    // Divider 2 gives a three-clock tick: ten ticks converting, three tracking
    check("conversion length", 32'd30, 32'(run_t[3]));
    check("8-bit shorter", 32'd6, 32'(run_t[0] - run_t[1]));
    check("delayed track", 32'd9, 32'(run_t[2]));
    // Non-burst series of four with window
    level = 10'($random(seed)) % 10'd1000 + 10'd1;
    wr(OFS_CFG, 32'h11);
    wr(OFS_ACC, 32'h1);
    wr(OFS_UPPER, 32'(level) * 4 - 1);
    wr(OFS_LOWER, 32'(level) * 4 + 1);
    for (int i = 0; i < 4; i++) begin
      if (i > 0) check("done mid series", 1'b0, rd[CTRL_DONE_BIT]);
      if (i > 0) check("window mid series", 1'b0, rd[CTRL_WIN_BIT]);
      wr(OFS_CTRL, 32'h90);
      poll(CTRL_BUSY_BIT, 1'b0);
    end
    check("done end series", 1'b1, rd[CTRL_DONE_BIT]);
    check("window hit", 1'b1, rd[CTRL_WIN_BIT]);
    bus(1'b0, OFS_RESULT, 32'h0);
    check("sum of four", 32'(level) * 4, rd);
    // Bursts of eight, powered down then kept enabled
    wr(OFS_ACC, 32'h2);
    wr(OFS_UPPER, 32'hffff);
    for (int e = 0; e < 2; e++) begin
      wr(OFS_CTRL, {24'h0, e[0], 7'h41});
      repeat (4) @(posedge clk_sys_in);
      check("idle power", e[0], adc_power_out);
      fire(SRC_T0);
      poll(CTRL_DONE_BIT, 1'b1);
      check("burst done", 1'b1, rd[CTRL_DONE_BIT]);
      bus(1'b0, OFS_RESULT, 32'h0);
      check("burst sum", 32'(level) * 8, rd);
      repeat (10) @(posedge clk_sys_in);
      check("power after burst", e[0], adc_power_out);
    end
    // Timer 2, timer 3 and pin sources, with a timer 0 trigger first
    wr(OFS_ACC, 32'h0);
    for (int k = 0; k < 3; k++) begin
      s = (k == 2) ? 3'h4 : SRC_T2 + 3'(k);
      level = 10'($random(seed));
      if (k == 2) wr(OFS_CFG, 32'h13);
      wr(OFS_CTRL, {24'h0, 5'h12, s});
      fire(SRC_T0);
      repeat (60) @(posedge clk_sys_in);
      check("idle track", 1'b1, track_out);
      bus(1'b0, OFS_CTRL, 32'h0);
      check("no start", 1'b0, rd[CTRL_DONE_BIT]);
      fire(s);
      poll(CTRL_DONE_BIT, 1'b1);
      bus(1'b0, OFS_RESULT, 32'h0);
      check("source result", 32'(level), rd);
    end
    standby_in <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    check("standby track", 1'b0, track_out);
    standby_in <= 1'b0;
    test_done();
  end
endmodule : testbench

`default_nettype wire
